// [verilog/bdsr_map.svh]
`ifndef BDSR_MAP_SVH
`define BDSR_MAP_SVH

`define BDSR_WIDTH      4
`define BDSR_RESET_VAL  4'h0
`define BDSR_BUF_DEPTH  2
`define BDSR_PTR_W      1
`define BDSR_CNT_W      2

`endif

// [verilog/bdsr_pkg.sv]
package bdsr_pkg;
	typedef enum logic [1:0] {
		BDSR_INHIBIT,
		BDSR_SHR,
		BDSR_SHL,
		BDSR_LOAD
	} bdsr_mode_t;
	typedef logic [3:0] bdsr_word_t;
endpackage

// [verilog/bdsr_buf.sv]
`timescale 1ns/100ps
`include "bdsr_map.svh"

module bdsr_buf (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   in_valid,
	output      logic                   in_ready,
	input  wire bdsr_pkg::bdsr_word_t   in_data,
	output      logic                   out_valid,
	input  wire logic                   out_ready,
	output      bdsr_pkg::bdsr_word_t   out_data
);
	bdsr_pkg::bdsr_word_t            mem_reg [`BDSR_BUF_DEPTH];
	logic [`BDSR_PTR_W-1:0]          wr_ptr_reg;
	logic [`BDSR_PTR_W-1:0]          rd_ptr_reg;
	logic [`BDSR_CNT_W-1:0]          count_reg;
	logic                            push;
	logic                            pop;

	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// Read data from a register; head always shown
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= 1'h0;
			rd_ptr_reg <= 1'h0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'h1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'h1;
			end
			count_reg <= count_reg + {1'h0, push} - {1'h0, pop};
		end
	end
endmodule

// [verilog/bdsr_top.sv]
`timescale 1ns/100ps
`include "bdsr_map.svh"

module bdsr_top (
	input  wire logic                   CLK_SYS,
	input  wire logic                   RESETN,
	input  wire logic                   CLEARN,
	input  wire logic                   MODE_SEL_HIGH,
	input  wire logic                   MODE_SEL_LOW,
	input  wire logic                   SER_RIGHT,
	input  wire logic                   SER_LEFT,
	input  wire bdsr_pkg::bdsr_word_t   PAR_IN,
	output      bdsr_pkg::bdsr_word_t   STAGE_Q,
	output      logic                   OUT_VALID,
	input  wire logic                   OUT_READY,
	output      bdsr_pkg::bdsr_word_t   OUT_DATA
);
	////////////////////////////////////////////////////////////////////////
	bdsr_pkg::bdsr_word_t   stage_reg;
	bdsr_pkg::bdsr_word_t   stage_next;
	bdsr_pkg::bdsr_mode_t   mode;
	logic                   clr_n;
	logic                   buf_ready;
	logic                   stall;

	function automatic bdsr_pkg::bdsr_mode_t decode_mode(input logic hi, input logic lo);
		bdsr_pkg::bdsr_mode_t m;
		m = bdsr_pkg::BDSR_INHIBIT;
		if (hi && lo) begin
			m = bdsr_pkg::BDSR_LOAD;
		end else if (lo) begin
			m = bdsr_pkg::BDSR_SHR;
		end else if (hi) begin
			m = bdsr_pkg::BDSR_SHL;
		end
		return m;
	endfunction

	// Mode and data come from logic on this clock, so no synchroniser
	assign mode  = decode_mode(MODE_SEL_HIGH, MODE_SEL_LOW);
	assign clr_n = RESETN && CLEARN;
	// Stalling the register while the buffer is full keeps every taken change published in the buffer
	assign stall = !buf_ready;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		stage_next = stage_reg;
		case (mode)
			bdsr_pkg::BDSR_LOAD: begin
				stage_next = PAR_IN;
			end
			bdsr_pkg::BDSR_SHR: begin
				stage_next = {stage_reg[2:0], SER_RIGHT};
			end
			bdsr_pkg::BDSR_SHL: begin
				stage_next = {SER_LEFT, stage_reg[3:1]};
			end
			default: begin
				stage_next = stage_reg;
			end
		endcase
	end

	// Bit 0 is the first stage, bit 3 the last
	always_ff @(posedge CLK_SYS or negedge clr_n) begin
		if (!clr_n) begin
			stage_reg <= `BDSR_RESET_VAL;
		end else if (!stall) begin
			stage_reg <= stage_next;
		end
	end

	assign STAGE_Q = stage_reg;

	////////////////////////////////////////////////////////////////////////
	logic   push_now;

	// The word enters the buffer at the same edge the stage takes it, so a
	// full buffer refuses both together and no word is lost in between
	assign push_now = (mode != bdsr_pkg::BDSR_INHIBIT);

	bdsr_buf u_buf (
		.clk       (CLK_SYS),
		.rst_n     (clr_n),
		.in_valid  (push_now),
		.in_ready  (buf_ready),
		.in_data   (stage_next),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  (OUT_DATA)
	);

	////////////////////////////////////////////////////////////////////////
	sequence s_load_req;
		MODE_SEL_HIGH && MODE_SEL_LOW && !stall;
	endsequence

	sequence s_shr_req;
		!MODE_SEL_HIGH && MODE_SEL_LOW && !stall;
	endsequence

	sequence s_shl_req;
		MODE_SEL_HIGH && !MODE_SEL_LOW && !stall;
	endsequence

	// Two shifts in a row move a bit by two stages
	sequence s_shr_twice;
		s_shr_req ##1 s_shr_req;
	endsequence

	sequence s_shl_twice;
		s_shl_req ##1 s_shl_req;
	endsequence

	a_load_value: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_load_req |=> STAGE_Q == $past(PAR_IN))
		else $error("parallel load value wrong");

	// Only fires when the serial level differs from the loaded bit
	a_load_no_serial: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_load_req ##0 (SER_RIGHT != PAR_IN[0]) |=>
		STAGE_Q[0] == $past(PAR_IN[0]))
		else $error("right serial data leaked into load");

	a_load_no_left: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_load_req ##0 (SER_LEFT != PAR_IN[3]) |=>
		STAGE_Q[3] == $past(PAR_IN[3]))
		else $error("left serial data leaked into load");

	a_shift_right2: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_shr_twice |=> STAGE_Q[3:2] == $past(STAGE_Q[1:0], 2))
		else $error("double right shift wrong");

	a_shift_left2: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_shl_twice |=> STAGE_Q[1:0] == $past(STAGE_Q[3:2], 2))
		else $error("double left shift wrong");

	a_shift_right: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_shr_req |=> STAGE_Q[3:1] == $past(STAGE_Q[2:0]))
		else $error("right shift wrong");

	a_right_entry: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		s_shr_req |=> STAGE_Q[0] == $past(SER_RIGHT))
		else $error("right serial entry wrong");

	a_shift_left: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		MODE_SEL_HIGH && !MODE_SEL_LOW && !stall |=>
		STAGE_Q == {$past(SER_LEFT), $past(STAGE_Q[3:1])})
		else $error("left shift wrong");

	a_inhibit_hold: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		!MODE_SEL_HIGH && !MODE_SEL_LOW |=> $stable(STAGE_Q))
		else $error("inhibit did not hold");

	a_stall_hold: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		stall |=> $stable(STAGE_Q))
		else $error("stage changed while stalled");

	a_clear_zero: assert property (@(posedge CLK_SYS)
		!CLEARN |-> STAGE_Q == 4'h0 && !OUT_VALID)
		else $error("clear did not force zero");

	a_reset_zero: assert property (@(posedge CLK_SYS)
		!RESETN |-> STAGE_Q == 4'h0 && !OUT_VALID)
		else $error("reset did not force zero");

	////////////////////////////////////////////////////////////////////////
	// Buffer side: every taken change is published once and held until popped
	a_push_shows: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		push_now && buf_ready |=> OUT_VALID)
		else $error("pushed word not visible");

	a_head_match: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		push_now && buf_ready && !OUT_VALID |=> OUT_DATA == STAGE_Q)
		else $error("head word differs from stage");

	a_out_hold: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
		else $error("unpopped word changed");

	a_refuse_hold: assert property (@(posedge CLK_SYS) disable iff (!clr_n)
		push_now && !buf_ready |=> $stable(STAGE_Q) && OUT_VALID)
		else $error("refused change was applied");
endmodule

// [tb/bdsr_sink.sv]
`timescale 1ns/100ps
module bdsr_sink (
	input  wire logic stall,
	output      logic ready
);
	// Stalls only on command, so the refusal point stays predictable
	assign ready = !stall;
endmodule

// [tb/bidir_four_bit_shift_register_tb.sv]
`timescale 1ns/100ps
module bidir_four_bit_shift_register_tb;
	logic                 clk = 0, rstn = 0, clrn = 1, hi = 0, lo = 0;
	logic                 sr = 0, sl = 0, stall = 0, full = 0, ov, rdy;
	logic [3:0]           par = 4'h0;
	bdsr_pkg::bdsr_word_t q, od, e;
	bdsr_pkg::bdsr_word_t fifo[$];
	int                   n_errors = 0, n_tests = 0, seed = 32'h320f6d87;
	always #20 clk = !clk;
	bdsr_top bdsr_top_i (.CLK_SYS(clk), .RESETN(rstn), .CLEARN(clrn), .MODE_SEL_HIGH(hi),
		.MODE_SEL_LOW(lo), .SER_RIGHT(sr), .SER_LEFT(sl), .PAR_IN(par), .STAGE_Q(q),
		.OUT_VALID(ov), .OUT_READY(rdy), .OUT_DATA(od));
	bdsr_sink bdsr_sink_i (.stall(stall), .ready(rdy));
	task chk(string n, logic [3:0] x, logic [3:0] y);
		n_tests++;
		if (x !== y) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, x, y);
		end
	endtask
	task cyc(logic h, logic l);
		logic [31:0] v;
		@(posedge clk);
		v = $random(seed);
		hi <= h;
		lo <= l;
		sr <= v[0];
		sl <= v[1];
		par <= v[7:4];
	endtask
	task final_report;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge rstn or negedge clrn) begin
		if (!rstn || !clrn) begin
			e = 4'h0;
			fifo.delete();
		end else begin
			// A full buffer refuses the change; mirrors the two-word depth
			full = (fifo.size() == 2);
			if (ov && rdy) chk("od", fifo.size() ? fifo.pop_front() : 4'hX, od);
			if ((hi || lo) && !full) begin
				case ({hi, lo})
					2'b11: e = par;
					2'b01: e = {e[2:0], sr};
					default: e = {sl, e[3:1]};
				endcase
				fifo.push_back(e);
			end
		end
	end
	always @(negedge clk) if (rstn) chk("q", e, q);
	initial begin
		logic [31:0] r;
		repeat (16) @(posedge clk);
		rstn <= 1;
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			cyc(r[0], r[1]);
		end
		repeat (3) cyc(0, 0);
		// Two words fill the buffer; the third load must be refused
		stall <= 1;
		cyc(1, 1);
		cyc(1, 1);
		repeat (4) cyc(0, 0);
		cyc(1, 1);
		cyc(0, 0);
		stall <= 0;
		for (int i = 0; i < 8 && fifo.size() > 0; i++) cyc(0, 0);
		chk("drain", 4'h0, 4'(fifo.size()));
		@(negedge clk);
		clrn <= 0;
		#1 chk("clr", 4'h0, q);
		chk("clrv", 4'h0, {3'b000, ov});
		cyc(1, 1);
		cyc(0, 0);
		clrn <= 1;
		repeat (20) cyc(1, 0);
		final_report;
	end
endmodule
